// ==== common/amsc_pkg.sv ====
// constants for the alert mask and shutdown control block
package amsc_pkg;
	localparam logic [7:0] AMSC_ADDR_CONFIG = 8'h73;
	localparam logic [7:0] AMSC_ADDR_MASK1 = 8'h74;
	localparam logic [7:0] AMSC_ADDR_MASK2 = 8'h75;
	localparam logic [7:0] AMSC_MASK1_RESET = 8'h00;
	localparam logic [7:0] AMSC_MASK2_RESET = 8'h00;
	localparam logic [7:0] AMSC_CONFIG_RESET = 8'h00;
	localparam logic [7:0] AMSC_UNMAPPED_READ = 8'h00;
	localparam logic [7:0] AMSC_DUTY_SHUTDOWN = 8'h00;
	localparam logic [7:0] AMSC_THERMAL_EVENT_PIN_LIMIT_NOW = 8'h00;
	// mask 1 fields
	localparam int AMSC_M1_V25 = 0;
	localparam int AMSC_M1_VCC = 2;
	localparam int AMSC_M1_REMOTE_ONE = 4;
	localparam int AMSC_M1_LOCAL = 5;
	localparam int AMSC_M1_REMOTE_TWO = 6;
	localparam int AMSC_M1_S2 = 7;
	// mask 2 fields
	localparam int AMSC_M2_OVERTEMP = 1;
	localparam int AMSC_M2_FAN_ONE = 2;
	localparam int AMSC_M2_FAN_THREE = 4;
	localparam int AMSC_M2_FOURTH = 5;
	localparam int AMSC_M2_DIODE_ONE = 6;
	localparam int AMSC_M2_DIODE_TWO = 7;
	// writable bits of mask 2
	localparam logic [7:0] AMSC_MASK2_WMASK = 8'hfd;
	// configuration fields
	localparam int AMSC_CFG_CONV = 6;
	localparam int AMSC_CFG_POWER_DOWN = 7;
	// single channel selector codes
	typedef enum logic [2:0] {
		AMSC_CH_V25 = 3'b000,
		AMSC_CH_VCC = 3'b010,
		AMSC_CH_REMOTE_ONE = 3'b101,
		AMSC_CH_LOCAL = 3'b110,
		AMSC_CH_REMOTE_TWO = 3'b111
	} amsc_chan_t;
endpackage

// ==== common/amsc_alert_if.sv ====
// carrier between register file and alert gate
`timescale 1ns/10ps
interface amsc_alert_if;
	logic [7:0] status_one;
	logic [7:0] status_two;
	logic [7:0] mask_one;
	logic [7:0] mask_two;
	logic fourth_is_thermal_event_pin;
	logic thermal_event_pin_timer_event;
	logic unmasked_any;
	modport regs (
		output status_one,
		output status_two,
		output mask_one,
		output mask_two,
		output fourth_is_thermal_event_pin,
		output thermal_event_pin_timer_event,
		input unmasked_any
	);
	modport gate (
		input status_one,
		input status_two,
		input mask_one,
		input mask_two,
		input fourth_is_thermal_event_pin,
		input thermal_event_pin_timer_event,
		output unmasked_any
	);
endinterface

// ==== rtl/amsc_alert_gate.sv ====
// masking of status sources into one alert request
`timescale 1ns/10ps
module amsc_alert_gate
	import amsc_pkg::*;
(
	amsc_alert_if.gate bus
);
	logic one_hit;
	logic two_hit;
	logic fourth_src;
	logic [7:0] two_src;

	always_comb begin
		// [R11] fan four or timer
		fourth_src = bus.fourth_is_thermal_event_pin ? bus.thermal_event_pin_timer_event :
			bus.status_two[AMSC_M2_FOURTH];
		two_src = bus.status_two;
		two_src[AMSC_M2_FOURTH] = fourth_src;
	end

	// [R5] voltage masks
	// [R6] temperature masks
	assign one_hit =
		(bus.status_one[AMSC_M1_V25] & ~bus.mask_one[AMSC_M1_V25]) |
		(bus.status_one[AMSC_M1_VCC] & ~bus.mask_one[AMSC_M1_VCC]) |
		(bus.status_one[AMSC_M1_REMOTE_ONE] &
		~bus.mask_one[AMSC_M1_REMOTE_ONE]) |
		(bus.status_one[AMSC_M1_LOCAL] & ~bus.mask_one[AMSC_M1_LOCAL]) |
		(bus.status_one[AMSC_M1_REMOTE_TWO] &
		~bus.mask_one[AMSC_M1_REMOTE_TWO]);

	// [R9] [R10] [R12] per bit fault masks
	// [R7] summary mask over status two
	assign two_hit = ~bus.mask_one[AMSC_M1_S2] &
		(|(two_src[AMSC_M2_DIODE_TWO:AMSC_M2_OVERTEMP] &
		~bus.mask_two[AMSC_M2_DIODE_TWO:AMSC_M2_OVERTEMP]));

	// [R16] any unmasked source
	assign bus.unmasked_any = one_hit | two_hit;
endmodule

// ==== rtl/amsc_top.sv ====
// alert masks, shutdown control and channel select
`timescale 1ns/10ps
// How it works
// [R1] the 3-bit selector picks 2.5 V, supply, remote one, local, remote two.
// [R2] the power-down bit parks every pwm output at its idle level, except the shared alert pin while alert_pin_enable is set.
// [R3] in shutdown every current duty readback reads 0x00.
// [R4] with the global lock set, configuration writes are ignored.
// [R5] mask one bits 0 and 2 block alerts from the 2.5 V and supply channels.
// [R6] mask one bits 4, 5 and 6 block remote one, local and remote two alerts.
// [R7] mask one bit 7 blocks every status two source whatever mask two holds.
// [R8] mask one resets to 0x00.
// [R9] mask two bit 1 masks overtemperature and is read-only to the host.
// [R10] mask two bits 2, 3 and 4 block fan one, two and three faults.
// [R11] mask two bit 5 blocks fan four, or the thermal_event_pin timer in thermal_event_pin mode.
// [R12] mask two bits 6 and 7 block remote one and remote two diode faults.
// [R13] mask two resets to 0x00.
// [R14] the masks only reach the pin once it is set up as the alert output.
// [R15] thermal_event_pin time above the limit sets the fan four/thermal_event_pin status bit.
// [R16] alert asserts while any set status bit named in R5, R6 and R9 to R12 is unmasked, else stays off.
module amsc_top
	import amsc_pkg::*;
#(
	parameter int NUM_PWM = 3,
	parameter int ALERT_PWM = 1
)(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic config_lock,
	input wire logic [2:0] chan_sel,
	output logic single_channel_mode,
	output logic [2:0] adc_channel,
	output logic adc_channel_valid,
	output logic in_shutdown,
	input wire logic [NUM_PWM-1:0] pwm_raw,
	input wire logic [NUM_PWM-1:0] pwm_park_high,
	input wire logic [NUM_PWM*8-1:0] duty_now,
	output logic [NUM_PWM*8-1:0] duty_readback,
	output logic [NUM_PWM-1:0] pwm_pin_o,
	output logic [NUM_PWM-1:0] pwm_pin_oe_n,
	input wire logic alert_pin_enable,
	input wire logic [7:0] status_one,
	input wire logic [7:0] status_two,
	input wire logic fourth_is_thermal_event_pin,
	input wire logic thermal_event_pin_asserted,
	input wire logic [7:0] thermal_event_pin_time,
	input wire logic [7:0] thermal_event_pin_limit,
	output logic thermal_event_pin_status_set,
	output logic alert_active
);
	logic [7:0] mask_one;
	logic [7:0] mask_two;
	logic [7:0] config_reg;
	logic thermal_event_pin_over;
	logic thermal_event_pin_over_q;
	logic [7:0] next_rdata;
	logic [2:0] next_channel;
	logic next_valid;
	amsc_alert_if gate_bus();

	////////////////////////////////////////////////////////////////////
	// register writes

	// [R8] mask one reset
	// [R5] mask one written
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mask_one <= AMSC_MASK1_RESET;
		end else if (reg_wr && reg_addr == AMSC_ADDR_MASK1) begin
			mask_one <= reg_wdata;
		end
	end

	// [R13] mask two reset
	// [R9] overtemperature bit not writable
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mask_two <= AMSC_MASK2_RESET;
		end else if (reg_wr && reg_addr == AMSC_ADDR_MASK2) begin
			mask_two <= (reg_wdata & AMSC_MASK2_WMASK) |
				(mask_two & ~AMSC_MASK2_WMASK);
		end
	end

	// [R4] lock blocks writes
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			config_reg <= AMSC_CONFIG_RESET;
		end else if (reg_wr && reg_addr == AMSC_ADDR_CONFIG &&
			!config_lock) begin
			config_reg <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// register reads

	always_comb begin
		case (reg_addr)
			AMSC_ADDR_MASK1: begin
				next_rdata = mask_one;
			end
			AMSC_ADDR_MASK2: begin
				next_rdata = mask_two;
			end
			AMSC_ADDR_CONFIG: begin
				next_rdata = config_reg;
			end
			default: begin
				next_rdata = AMSC_UNMAPPED_READ;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reg_rdata <= AMSC_UNMAPPED_READ;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////
	// single channel selection

	// [R1] selector decode
	always_comb begin
		next_channel = chan_sel;
		case (chan_sel)
			AMSC_CH_V25, AMSC_CH_VCC, AMSC_CH_REMOTE_ONE,
			AMSC_CH_LOCAL, AMSC_CH_REMOTE_TWO: begin
				next_valid = 1'b1;
			end
			default: begin
				next_valid = 1'b0;
				next_channel = AMSC_CH_V25;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			single_channel_mode <= 1'b0;
			adc_channel <= AMSC_CH_V25;
			adc_channel_valid <= 1'b0;
		end else begin
			single_channel_mode <= config_reg[AMSC_CFG_CONV];
			adc_channel <= next_channel;
			adc_channel_valid <= next_valid;
		end
	end

	////////////////////////////////////////////////////////////////////
	// shutdown of pwm outputs and duty readback

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			in_shutdown <= 1'b0;
		end else begin
			in_shutdown <= config_reg[AMSC_CFG_POWER_DOWN];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PWM; gi++) begin : g_pwm
			// [R3] duty reads zero
			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					duty_readback[gi*8 +: 8] <= AMSC_DUTY_SHUTDOWN;
				end else if (config_reg[AMSC_CFG_POWER_DOWN]) begin
					duty_readback[gi*8 +: 8] <= AMSC_DUTY_SHUTDOWN;
				end else begin
					duty_readback[gi*8 +: 8] <= duty_now[gi*8 +: 8];
				end
			end

			// [R2] park level in shutdown
			// [R14] shared pin as open drain alert
			always_ff @(posedge sys_clk) begin
				if (sys_rst) begin
					pwm_pin_o[gi] <= 1'b0;
					pwm_pin_oe_n[gi] <= 1'b1;
				end else if (gi == ALERT_PWM && alert_pin_enable) begin
					pwm_pin_o[gi] <= 1'b0;
					pwm_pin_oe_n[gi] <= ~gate_bus.unmasked_any;
				end else if (config_reg[AMSC_CFG_POWER_DOWN]) begin
					pwm_pin_o[gi] <= pwm_park_high[gi];
					pwm_pin_oe_n[gi] <= 1'b0;
				end else begin
					pwm_pin_o[gi] <= pwm_raw[gi];
					pwm_pin_oe_n[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// thermal_event_pin timer event

	// [R15] time over limit
	assign thermal_event_pin_over = thermal_event_pin_asserted &&
		(thermal_event_pin_limit == AMSC_THERMAL_EVENT_PIN_LIMIT_NOW || thermal_event_pin_time > thermal_event_pin_limit);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			thermal_event_pin_over_q <= 1'b0;
			thermal_event_pin_status_set <= 1'b0;
		end else begin
			thermal_event_pin_over_q <= thermal_event_pin_over;
			thermal_event_pin_status_set <= thermal_event_pin_over && !thermal_event_pin_over_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// alert gating

	assign gate_bus.status_one = status_one;
	assign gate_bus.status_two = status_two;
	assign gate_bus.mask_one = mask_one;
	assign gate_bus.mask_two = mask_two;
	assign gate_bus.fourth_is_thermal_event_pin = fourth_is_thermal_event_pin;
	assign gate_bus.thermal_event_pin_timer_event = status_two[AMSC_M2_FOURTH];

	amsc_alert_gate u_gate (
		.bus(gate_bus)
	);

	// [R16] registered alert
	// [R14] only when pin enabled
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			alert_active <= 1'b0;
		end else begin
			alert_active <= alert_pin_enable & gate_bus.unmasked_any;
		end
	end
endmodule

// ==== verification/amsc_top_properties.sv ====
// port assertions for the alert and shutdown block
`timescale 1ns/10ps
module amsc_top_properties
	import amsc_pkg::*;
#(
	parameter int NUM_PWM = 3,
	parameter int ALERT_PWM = 1
)(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [2:0] chan_sel,
	input wire logic [2:0] adc_channel,
	input wire logic adc_channel_valid,
	input wire logic in_shutdown,
	input wire logic [NUM_PWM*8-1:0] duty_readback,
	input wire logic [NUM_PWM-1:0] pwm_pin_oe_n,
	input wire logic alert_pin_enable,
	input wire logic [7:0] status_one,
	input wire logic [7:0] status_two,
	input wire logic thermal_event_pin_asserted,
	input wire logic thermal_event_pin_status_set,
	input wire logic alert_active
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	a_chan_legal: assert property (adc_channel_valid |->
		$past(chan_sel) inside {3'b000, 3'b010, 3'b101, 3'b110, 3'b111}
		&& adc_channel == $past(chan_sel)) else $error("bad channel");
	a_shutdown_duty: assert property (in_shutdown |->
		duty_readback == '0) else $error("duty not zero");
	a_overtemp_ro: assert property (reg_rd && reg_addr == AMSC_ADDR_MASK2
		|=> !reg_rdata[AMSC_M2_OVERTEMP]) else $error("overtemp bit set");
	a_thermal_event_pin_once: assert property (thermal_event_pin_status_set |=>
		!thermal_event_pin_status_set) else $error("thermal_event_pin pulse long");
	a_thermal_event_pin_src: assert property (thermal_event_pin_status_set |->
		$past(thermal_event_pin_asserted)) else $error("thermal_event_pin pulse uncaused");
	a_alert_gate: assert property (!alert_pin_enable |=>
		!alert_active) else $error("alert while disabled");
	a_alert_quiet: assert property (status_one == 0 && status_two == 0
		|=> !alert_active) else $error("alert without cause");
	a_alert_pin: assert property (alert_active |->
		!pwm_pin_oe_n[ALERT_PWM]) else $error("alert pin not driven");
endmodule
bind amsc_top amsc_top_properties #(.NUM_PWM(NUM_PWM), .ALERT_PWM(ALERT_PWM))
	chk_u (.*);

// ==== verification/amsc_host_model.sv ====
// host driving the byte register port
`timescale 1ns/10ps
module amsc_host_model(
	input wire logic sys_clk,
	input wire logic [7:0] reg_rdata,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		{reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(negedge sys_clk);
		{reg_wdata, reg_wr} = {~d, 1'b0};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		{reg_addr, reg_rd} = {a, 1'b1};
		@(negedge sys_clk);
		reg_rd = 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask
endmodule

// ==== verification/test_alert_mask_and_shutdown_control.sv ====
// self-checking bench for the alert and shutdown block
`timescale 1ns/10ps
module test_alert_mask_and_shutdown_control
	import amsc_pkg::*;
;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, status_one, status_two, d;
	logic [7:0] thermal_event_pin_time, thermal_event_pin_limit;
	logic reg_wr, reg_rd, config_lock, single_channel_mode, adc_channel_valid;
	logic in_shutdown, alert_pin_enable, fourth_is_thermal_event_pin, thermal_event_pin_asserted;
	logic thermal_event_pin_status_set, alert_active;
	logic [2:0] chan_sel, adc_channel, pwm_raw, pwm_park_high, pwm_pin_o;
	logic [2:0] pwm_pin_oe_n;
	logic [23:0] duty_now, duty_readback;
	int miscompares = 0;
	int checked = 0;
	always #12.5 sys_clk = ~sys_clk;
	amsc_top dut_u (.*);
	amsc_host_model host_u (.*);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h not %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic finish_test;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic t_reset;
		host_u.rd(AMSC_ADDR_MASK1, d);
		chk(d, 8'h00);
		host_u.rd(AMSC_ADDR_MASK2, d);
		chk(d, 8'h00);
	endtask
	task automatic t_alert;
		logic [7:0] m1, m2, e;
		logic [15:0] tbl [3] = '{16'h50ac, 16'h8500, 16'h0053};
		alert_pin_enable = 1'b1;
		foreach (tbl[k]) begin
			fourth_is_thermal_event_pin = (k == 2);
			m1 = tbl[k][15:8];
			host_u.wr(AMSC_ADDR_MASK1, m1);
			host_u.wr(AMSC_ADDR_MASK2, tbl[k][7:0]);
			host_u.rd(AMSC_ADDR_MASK2, m2);
			chk(m2, tbl[k][7:0] & 8'hfd);
			for (int i = 0; i < 16; i++) begin
				{status_two, status_one} = 16'h1 << i;
				cyc(2);
				e = i < 8 ? (8'h75 & ~m1) >> i
					: (m1[7] ? 8'h00 : 8'hfe & ~(tbl[k][7:0] & 8'hfd))
					>> (i - 8);
				chk(alert_active, e[0]);
				chk(pwm_pin_oe_n[1], !e[0]);
			end
		end
		{status_two, status_one} = 16'h0001;
		alert_pin_enable = 1'b0;
		cyc(2);
		chk(alert_active, 1'b0);
		status_one = 8'h00;
	endtask
	task automatic t_cfg;
		{pwm_raw, pwm_park_high, duty_now} = {3'b010, 3'b101, 24'h123456};
		config_lock = 1'b1;
		host_u.wr(AMSC_ADDR_CONFIG, 8'hc0);
		cyc(2);
		chk({single_channel_mode, in_shutdown, duty_readback}, 26'h123456);
		config_lock = 1'b0;
		host_u.wr(AMSC_ADDR_CONFIG, 8'hc0);
		cyc(2);
		chk({single_channel_mode, in_shutdown, duty_readback}, 26'h3000000);
		chk(pwm_pin_o, 3'b101);
		chk(pwm_pin_oe_n, 3'b000);
		for (int c = 0; c < 8; c++) begin
			chan_sel = c[2:0];
			cyc(2);
			chk({adc_channel_valid, adc_channel}, (c inside {0, 2, 5, 6, 7})
				? {1'b1, c[2:0]} : 4'h0);
		end
		config_lock = 1'b1;
		host_u.wr(AMSC_ADDR_CONFIG, 8'h00);
		cyc(2);
		chk(in_shutdown, 1'b1);
	endtask
	task automatic t_thermal_event_pin;
		int n;
		logic [23:0] tbl [3] = '{24'h102001, 24'h101000, 24'h000001};
		foreach (tbl[k]) begin
			{thermal_event_pin_limit, thermal_event_pin_time} = tbl[k][23:8];
			thermal_event_pin_asserted = 1'b1;
			n = 0;
			repeat (6) begin
				@(negedge sys_clk);
				n += thermal_event_pin_status_set;
			end
			chk(n, tbl[k][7:0]);
			thermal_event_pin_asserted = 1'b0;
			cyc(2);
		end
	endtask
	initial begin
		{config_lock, alert_pin_enable, fourth_is_thermal_event_pin, thermal_event_pin_asserted} = 4'h0;
		{status_one, status_two, thermal_event_pin_time, thermal_event_pin_limit} = 32'h0;
		{chan_sel, pwm_raw, pwm_park_high, duty_now} = 33'h0;
		cyc(20);
		sys_rst = 1'b0;
		t_reset;
		t_alert;
		t_cfg;
		t_thermal_event_pin;
		finish_test;
	end
	initial begin
		cyc(20000);
		miscompares++;
		finish_test;
	end
endmodule
